// ### bench/pwr_sys_chk.sv
// Port checker for the power and system control register bank.
// Bound to the design instance from the testbench top file.
`timescale 1ns/1ps
module pwr_sys_chk (
  // Clock, reset and access
  input wire logic                        mclk,
  input wire logic                        rst_n,
  input wire pwr_sys_pkg::reg_access_type cpu_acc,
  input wire logic                        cpu_hit,
  // Sleep, fuses and controls
  input wire logic                        sleep_instr,
  input wire logic                        wake_event,
  input wire logic                        sleep_go,
  input wire logic                        cpu_resume,
  input wire logic                        jtag_fuse,
  input wire logic                        jtag_enable,
  input wire logic                        irq_block,
  input wire logic                        timer_two_async_select,
  input wire logic [7:0]                  clock_stop,
  input wire logic                        comparator_mux_block
);
  logic       acc_any;
  logic [7:0] dsa;
  logic       exp_hit;

  // Data-space view of the access; gate register never via short I/O
  assign acc_any = cpu_acc.wr | cpu_acc.rd;
  assign dsa     = cpu_acc.io_space ? cpu_acc.addr + pwr_sys_pkg::IO_DELTA : cpu_acc.addr;
  assign exp_hit = acc_any & (dsa == pwr_sys_pkg::OFS_SLEEP | dsa == pwr_sys_pkg::OFS_SYSCTL
                   | (dsa == pwr_sys_pkg::OFS_GATE & !cpu_acc.io_space));

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_hit_decoded: assert property (exp_hit |=> cpu_hit)
    else $error("decoded access not answered");
  a_miss_refused: assert property (acc_any && !exp_hit |=> !cpu_hit)
    else $error("undecoded access answered");
  a_hit_cause: assert property (cpu_hit |-> $past(acc_any))
    else $error("hit without access");
  a_sleep_cause: assert property (sleep_go |-> $past(sleep_instr))
    else $error("sleep accepted without request");
  a_resume_six: assert property (cpu_resume |-> $past(wake_event, 6))
    else $error("resume not six cycles after wake");
  a_unlock_blocks: assert property (cpu_acc.wr && dsa == pwr_sys_pkg::OFS_SYSCTL
    && cpu_acc.wdata[pwr_sys_pkg::SC_VEC_UNLK] |=> irq_block)
    else $error("vector unlock did not block interrupts");
  a_jtag_fuse: assert property (jtag_enable && $stable(jtag_fuse) |-> jtag_fuse)
    else $error("debug port on without fuse");
  a_timer_two_sync: assert property (clock_stop[6] && $stable(timer_two_async_select)
    |-> !timer_two_async_select)
    else $error("asynchronous timer two gated");
  a_mux_follows: assert property (comparator_mux_block == clock_stop[0])
    else $error("comparator mux block differs from converter gate");

  // Main scenarios reached
  c_sleep: cover property (sleep_go);
  c_resume: cover property (cpu_resume);
  c_unblock: cover property ($fell(irq_block));
endmodule : pwr_sys_chk

// ### bench/testbench.sv
// Bench for the power and system control register bank.
// Drives the CPU port itself; the checker is bound at the foot.
`timescale 1ns/1ps
module testbench;
  logic                        mclk = 1'b0;
  logic                        rst_n = 1'b0;
  pwr_sys_pkg::reg_access_type cpu_acc = '0;
  pwr_sys_pkg::exec_ctx_type   exec_ctx = '0;
  logic                        sleep_instr = 1'b0;
  logic                        wake_event = 1'b0;
  logic                        jtag_fuse = 1'b1;
  logic                        timer_two_async_select = 1'b0;
  logic [7:0]                  cpu_rdata, clock_stop, periph_access_block;
  logic [2:0]                  sleep_mode;
  logic                        cpu_hit, sleep_go, brownout_off_in_sleep, cpu_resume, jtag_enable;
  logic                        pullup_global_off, vector_table_select, irq_block, comparator_mux_block;
  int                          num_errors = 0;
  int                          checked = 0;

  // 125 MHz clock
  always #4 mclk = ~mclk;

  power_and_system_control_regs power_and_system_control_regs_i (
    .mclk, .rst_n, .cpu_acc, .cpu_rdata, .cpu_hit, .sleep_instr, .wake_event, .sleep_go,
    .sleep_mode, .brownout_off_in_sleep, .cpu_resume, .jtag_fuse, .exec_ctx,
    .timer_two_async_select, .jtag_enable, .pullup_global_off, .vector_table_select,
    .irq_block, .clock_stop, .periph_access_block, .comparator_mux_block
  );

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_bit(input logic got, input logic exp);
    check_val({7'h00, got}, {7'h00, exp});
  endtask : check_bit

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // One access pulse; answer is settled just after the next edge
  task automatic xfer(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_acc <= '{w, !w, io, a, d};
    @(posedge mclk);
    cpu_acc <= '0;
    #1;
  endtask : xfer

  task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] exp, input logic hit);
    xfer(1'b0, io, a, 8'h00);
    check_val(cpu_rdata, exp);
    check_bit(cpu_hit, hit);
  endtask : rd

  // Sleep request, then a wake; resume only when sleep was taken
  task automatic sleep_try(input logic go, input logic brownout_detector);
    int n;
    @(posedge mclk);
    sleep_instr <= 1'b1;
    @(posedge mclk);
    sleep_instr <= 1'b0;
    #1;
    check_bit(sleep_go, go);
    check_bit(brownout_off_in_sleep, brownout_detector);
    @(posedge mclk);
    wake_event <= 1'b1;
    @(posedge mclk);
    wake_event <= 1'b0;
    n = 0;
    while (cpu_resume !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    check_bit(cpu_resume, go);
  endtask : sleep_try

  task automatic print_verdict;
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    num_errors++;
    print_verdict();
  end

  // Test sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    tick(1);
    rd(0, 8'h53, 8'h00, 1'b1);
    rd(0, 8'h55, 8'h00, 1'b1);
    rd(0, 8'h64, 8'h00, 1'b1);
    check_bit(jtag_enable, 1'b1);
    xfer(1, 1, 8'h33, 8'hFF);
    rd(0, 8'h53, 8'h0F, 1'b1);
    // Each defined mode, unarmed then armed
    for (int m = 0; m < 8; m++)
    begin
      if (m == 4 || m == 5)
        continue;
      xfer(1, 1, 8'h33, 8'(m << 1));
      sleep_try(1'b0, 1'b0);
      xfer(1, 0, 8'h53, 8'(m << 1) | 8'h01);
      sleep_try(1'b1, 1'b0);
      check_val({5'h00, sleep_mode}, 8'(m));
    end
    // Brown-out sleep-off sequence, lone write, and sleep in window
    xfer(1, 0, 8'h55, 8'h1C);
    rd(0, 8'h55, 8'h10, 1'b1);
    check_bit(pullup_global_off, 1'b1);
    xfer(1, 0, 8'h55, 8'h70);
    xfer(1, 0, 8'h55, 8'h50);
    rd(0, 8'h55, 8'h50, 1'b1);
    tick(8);
    rd(0, 8'h55, 8'h10, 1'b1);
    xfer(1, 0, 8'h55, 8'h50);
    rd(0, 8'h55, 8'h10, 1'b1);
    xfer(1, 0, 8'h55, 8'h70);
    xfer(1, 0, 8'h55, 8'h50);
    tick(2);
    sleep_try(1'b1, 1'b1);
    // Debug port bit needs two equal writes close together
    xfer(1, 0, 8'h55, 8'h90);
    tick(4);
    rd(0, 8'h55, 8'h10, 1'b1);
    xfer(1, 0, 8'h55, 8'h90);
    xfer(1, 0, 8'h55, 8'h90);
    rd(0, 8'h55, 8'h90, 1'b1);
    check_bit(jtag_enable, 1'b0);
    xfer(1, 0, 8'h55, 8'h10);
    xfer(1, 0, 8'h55, 8'h10);
    // Vector move, refused move, and expired unlock
    xfer(1, 0, 8'h55, 8'h11);
    xfer(1, 0, 8'h55, 8'h12);
    rd(0, 8'h55, 8'h12, 1'b1);
    check_bit(vector_table_select, 1'b1);
    xfer(1, 0, 8'h55, 8'h10);
    rd(0, 8'h55, 8'h12, 1'b1);
    xfer(1, 0, 8'h55, 8'h11);
    tick(6);
    check_bit(irq_block, 1'b0);
    xfer(1, 0, 8'h55, 8'h10);
    rd(0, 8'h55, 8'h12, 1'b1);
    @(posedge mclk);
    exec_ctx <= '{1'b0, 1'b1, 1'b0};
    tick(2);
    check_bit(irq_block, 1'b1);
    // Walk one gate bit through the register
    for (int i = 0; i < 8; i++)
    begin
      // No debug link or serial module here, so no re-init is owed
      xfer(1, 0, 8'h64, 8'h01 << i);
      rd(0, 8'h64, 8'h01 << i, 1'b1);
      check_val(clock_stop, 8'h01 << i);
      check_val(periph_access_block, 8'h01 << i);
      check_bit(comparator_mux_block, i == 0);
    end
    @(posedge mclk);
    timer_two_async_select <= 1'b1;
    xfer(1, 0, 8'h64, 8'h40);
    tick(2);
    check_val(clock_stop, 8'h00);
    @(posedge mclk);
    timer_two_async_select <= 1'b0;
    tick(2);
    check_val(clock_stop, 8'h40);
    xfer(1, 1, 8'h44, 8'hFF);
    rd(0, 8'h64, 8'h40, 1'b1);
    rd(1, 8'h44, 8'h00, 1'b0);
    print_verdict();
  end
endmodule : testbench

bind power_and_system_control_regs pwr_sys_chk pwr_sys_chk_i (
  .mclk, .rst_n, .cpu_acc, .cpu_hit, .sleep_instr, .wake_event, .sleep_go, .cpu_resume,
  .jtag_fuse, .jtag_enable, .irq_block, .timer_two_async_select, .clock_stop, .comparator_mux_block
);

// ### src/power_and_system_control_regs.sv
// Sleep, system and peripheral clock-gate registers of the controller core.
// Assumes single-cycle CPU accesses synchronous to mclk, the CPU's own sleep
// sequencer, and fuse/lock levels that are static during operation.
// Behaviour
// [RL1] Three-bit field selects the sleep mode
// [RL2] Sleep only when the arm bit is set
// [RL3] Software arms just before sleep, clears after
// [RL4] Short I/O address is offset minus 0x20
// [RL5] Extended space reachable only by data space
// [RL6] JTAG off bit disables port, else fuse
// [RL7] JTAG bit changes on two writes in four
// [RL8] Brown-out sleep-off needs timed unlock sequence
// [RL9] Brown-out off active after three, clears after three
// [RL10] Detector off only if sleep during window
// [RL11] Pull-up off bit overrides all pin pull-ups
// [RL12] Vector select picks flash start or boot
// [RL13] Vector select changes only after unlock write
// [RL14] Interrupts blocked during the vector change sequence
// [RL15] Vector unlock clears after four or select
// [RL16] Lock bits block interrupts in other section
// [RL17] Gate bits stop peripheral clocks, fixed mapping
// [RL18] Timer two gated only when synchronous
// [RL19] Gated timers resume from their held state
// [RL20] Software re-initialises serial modules after ungating
// [RL21] Converter gating cuts comparator multiplexer use
// [RL22] Software avoids gating serial peripheral during debug
// [RL23] Gated peripheral registers frozen and inaccessible
// [RL24] Standby wake-up resumes after six cycles
// [RL25] Unimplemented bits read zero, ignore writes
`timescale 1ns/1ps
module power_and_system_control_regs (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // CPU register access
  input  wire pwr_sys_pkg::reg_access_type cpu_acc,
  output logic [7:0]                      cpu_rdata,
  output logic                            cpu_hit,
  // CPU sleep interface
  input  wire logic                       sleep_instr,
  input  wire logic                       wake_event,
  output logic                            sleep_go,
  output logic [2:0]                      sleep_mode,
  output logic                            brownout_off_in_sleep,
  output logic                            cpu_resume,
  // Fuses, lock bits and execution context
  input  wire logic                       jtag_fuse,
  input  wire pwr_sys_pkg::exec_ctx_type  exec_ctx,
  input  wire logic                       timer_two_async_select,
  // System controls
  output logic                            jtag_enable,
  output logic                            pullup_global_off,
  output logic                            vector_table_select,
  output logic                            irq_block,
  // Peripheral clock gates and access blocks
  output logic [7:0]                      clock_stop,
  output logic [7:0]                      periph_access_block,
  output logic                            comparator_mux_block
);

  logic [3:0] sleep_r;
  logic       jtag_off_r;
  logic       jtag_pend_r;
  logic       jtag_val_r;
  logic [2:0] jtag_cnt_r;
  logic       bod_unlk_r;
  logic [2:0] bod_unlk_cnt_r;
  logic       bod_off_r;
  logic [2:0] bod_cnt_r;
  logic       pull_off_r;
  logic       vec_sel_r;
  logic       vec_unlk_r;
  logic [2:0] vec_cnt_r;
  logic       vec_tail_r;
  logic [7:0] gate_r;
  logic       asleep_r;
  logic       wake_pend_r;
  logic [2:0] wake_cnt_r;

  logic [7:0] eff_addr;
  logic       hit_sleep;
  logic       hit_sys;
  logic       hit_gate;
  logic       wr_sys;
  logic [7:0] wd;
  logic       bod_active;
  logic       sleep_take;

  // Address mapping; the gate register has no short I/O alias
  always_comb
  begin
    eff_addr = cpu_acc.addr + pwr_sys_pkg::IO_DELTA; // RL4
    if (!cpu_acc.io_space)
      eff_addr = cpu_acc.addr;
    hit_sleep = (eff_addr == pwr_sys_pkg::OFS_SLEEP);
    hit_sys   = (eff_addr == pwr_sys_pkg::OFS_SYSCTL);
    hit_gate  = !cpu_acc.io_space && (eff_addr == pwr_sys_pkg::OFS_GATE); // RL5
    if (cpu_acc.io_space && cpu_acc.addr > pwr_sys_pkg::IO_LIMIT)
    begin
      hit_sleep = 1'b0;
      hit_sys   = 1'b0;
    end
  end

  assign wr_sys = cpu_acc.wr && hit_sys;
  assign wd     = cpu_acc.wdata;

  // Brown-out off counts as active from the third cycle after setting
  assign bod_active = bod_off_r && (bod_cnt_r >= pwr_sys_pkg::BOD_DELAY); // RL9
  assign sleep_take = sleep_instr && sleep_r[pwr_sys_pkg::SLP_ARM_BIT] && !asleep_r; // RL2

  // Sleep control register, bits 7..4 not stored
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sleep_r <= 4'h0;
    else if (cpu_acc.wr && hit_sleep)
      sleep_r <= wd[3:0]; // RL25
  end

  // JTAG off: a value must be written twice within the window
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jtag_off_r  <= 1'b0;
      jtag_pend_r <= 1'b0;
      jtag_val_r  <= 1'b0;
      jtag_cnt_r  <= 3'h0;
    end
    else if (wr_sys)
    begin
      if (jtag_pend_r && jtag_val_r == wd[pwr_sys_pkg::SC_JTAG_OFF])
      begin
        jtag_off_r  <= wd[pwr_sys_pkg::SC_JTAG_OFF]; // RL7
        jtag_pend_r <= 1'b0;
      end
      else
      begin
        jtag_pend_r <= 1'b1;
        jtag_val_r  <= wd[pwr_sys_pkg::SC_JTAG_OFF];
        jtag_cnt_r  <= 3'h1;
      end
    end
    else if (jtag_pend_r)
    begin
      jtag_cnt_r <= jtag_cnt_r + 3'h1;
      if (jtag_cnt_r >= pwr_sys_pkg::UNLOCK_WINDOW - 3'h1)
        jtag_pend_r <= 1'b0; // RL7
    end
  end

  // Brown-out sleep-off unlock and self-clearing bit
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bod_unlk_r     <= 1'b0;
      bod_unlk_cnt_r <= 3'h0;
      bod_off_r      <= 1'b0;
      bod_cnt_r      <= 3'h0;
    end
    else
    begin
      if (wr_sys && wd[pwr_sys_pkg::SC_BOD_OFF] && wd[pwr_sys_pkg::SC_BOD_UNLK])
      begin
        bod_unlk_r     <= 1'b1; // RL8
        bod_unlk_cnt_r <= 3'h0;
      end
      else if (wr_sys && bod_unlk_r)
      begin
        bod_unlk_r <= 1'b0;
        if (wd[pwr_sys_pkg::SC_BOD_OFF] && !wd[pwr_sys_pkg::SC_BOD_UNLK])
        begin
          bod_off_r <= 1'b1; // RL8
          bod_cnt_r <= 3'h0;
        end
      end
      else if (bod_unlk_r)
      begin
        bod_unlk_cnt_r <= bod_unlk_cnt_r + 3'h1;
        if (bod_unlk_cnt_r >= pwr_sys_pkg::UNLOCK_WINDOW - 3'h1)
          bod_unlk_r <= 1'b0;
      end
      // Self-clear three cycles after becoming active
      if (bod_off_r && !(wr_sys && bod_unlk_r))
      begin
        bod_cnt_r <= bod_cnt_r + 3'h1;
        if (bod_cnt_r >= pwr_sys_pkg::BOD_DELAY + pwr_sys_pkg::BOD_DELAY - 3'h1)
          bod_off_r <= 1'b0; // RL9
      end
    end
  end

  // Pull-up override is a plain bit
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pull_off_r <= 1'b0;
    else if (wr_sys)
      pull_off_r <= wd[pwr_sys_pkg::SC_PULL_OFF]; // RL11
  end

  // Vector select with unlock; unlock expires or is consumed
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vec_sel_r  <= 1'b0;
      vec_unlk_r <= 1'b0;
      vec_cnt_r  <= 3'h0;
      vec_tail_r <= 1'b0;
    end
    else
    begin
      vec_tail_r <= 1'b0;
      if (wr_sys && wd[pwr_sys_pkg::SC_VEC_UNLK])
      begin
        vec_unlk_r <= 1'b1; // RL13
        vec_cnt_r  <= 3'h0;
      end
      else if (wr_sys && vec_unlk_r)
      begin
        vec_sel_r  <= wd[pwr_sys_pkg::SC_VEC_SEL]; // RL13
        vec_unlk_r <= 1'b0; // RL15
        vec_tail_r <= 1'b1; // RL14
      end
      else if (vec_unlk_r)
      begin
        vec_cnt_r <= vec_cnt_r + 3'h1;
        if (vec_cnt_r >= pwr_sys_pkg::UNLOCK_WINDOW - 3'h1)
          vec_unlk_r <= 1'b0; // RL15
      end
    end
  end

  // Clock gate register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      gate_r <= pwr_sys_pkg::RESET_VAL;
    else if (cpu_acc.wr && hit_gate)
      gate_r <= wd; // RL17
  end

  // Sleep state and wake-up delay counting
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      asleep_r    <= 1'b0;
      wake_pend_r <= 1'b0;
      wake_cnt_r  <= 3'h0;
    end
    else if (sleep_take)
      asleep_r <= 1'b1;
    else if (asleep_r && wake_event && !wake_pend_r)
    begin
      wake_pend_r <= 1'b1;
      wake_cnt_r  <= 3'h1;
    end
    else if (wake_pend_r)
    begin
      wake_cnt_r <= wake_cnt_r + 3'h1;
      if (wake_cnt_r >= pwr_sys_pkg::STANDBY_WAKE - 3'h1)
      begin
        wake_pend_r <= 1'b0; // RL24
        asleep_r    <= 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_rdata             <= 8'h00;
      cpu_hit               <= 1'b0;
      sleep_go              <= 1'b0;
      sleep_mode            <= 3'h0;
      brownout_off_in_sleep <= 1'b0;
      cpu_resume            <= 1'b0;
      jtag_enable           <= 1'b0;
      pullup_global_off     <= 1'b0;
      vector_table_select   <= 1'b0;
      irq_block             <= 1'b0;
      clock_stop            <= 8'h00;
      periph_access_block   <= 8'h00;
      comparator_mux_block  <= 1'b0;
    end
    else
    begin
      cpu_hit   <= (cpu_acc.rd || cpu_acc.wr) && (hit_sleep || hit_sys || hit_gate);
      cpu_rdata <= 8'h00;
      if (cpu_acc.rd && hit_sleep)
        cpu_rdata <= {4'h0, sleep_r}; // RL25
      else if (cpu_acc.rd && hit_sys)
        cpu_rdata <= {jtag_off_r, bod_off_r, bod_unlk_r, pull_off_r, 2'h0, vec_sel_r, vec_unlk_r}
                     & pwr_sys_pkg::SC_MASK; // RL25
      else if (cpu_acc.rd && hit_gate)
        cpu_rdata <= gate_r;
      sleep_go   <= sleep_take; // RL2
      sleep_mode <= sleep_r[pwr_sys_pkg::SLP_SEL_LO +: 3]; // RL1
      if (sleep_take)
        brownout_off_in_sleep <= bod_active; // RL10
      else if (!asleep_r)
        brownout_off_in_sleep <= 1'b0;
      cpu_resume          <= wake_pend_r && (wake_cnt_r >= pwr_sys_pkg::STANDBY_WAKE - 3'h1); // RL24
      jtag_enable         <= jtag_fuse && !jtag_off_r; // RL6
      pullup_global_off   <= pull_off_r; // RL11
      vector_table_select <= vec_sel_r; // RL12
      irq_block           <= (wr_sys && wd[pwr_sys_pkg::SC_VEC_UNLK]) || vec_unlk_r || vec_tail_r // RL14
                             || (vec_sel_r && exec_ctx.app_lock && !exec_ctx.in_boot) // RL16
                             || (!vec_sel_r && exec_ctx.boot_lock && exec_ctx.in_boot); // RL16
      clock_stop <= gate_r; // RL17 RL19
      clock_stop[pwr_sys_pkg::GT_TIMER_TWO] <= gate_r[pwr_sys_pkg::GT_TIMER_TWO] && !timer_two_async_select; // RL18
      periph_access_block  <= gate_r; // RL23
      comparator_mux_block <= gate_r[0]; // RL21
    end
  end

endmodule : power_and_system_control_regs

// ### src/pwr_sys_pkg.sv
// Constants and carriers for the power and system control register bank.
// Assumes a CPU-side data-space/I/O-space access port on the system clock.
package pwr_sys_pkg;

  // Data-space offsets and the short I/O address offset
  localparam logic [7:0] OFS_SLEEP   = 8'h53;
  localparam logic [7:0] OFS_SYSCTL  = 8'h55;
  localparam logic [7:0] OFS_GATE    = 8'h64;
  localparam logic [7:0] IO_DELTA    = 8'h20;
  localparam logic [7:0] EXT_IO_BASE = 8'h60;
  localparam logic [7:0] IO_LIMIT    = 8'h3F;
  localparam logic [7:0] RESET_VAL   = 8'h00;

  // Sleep register fields
  localparam int SLP_ARM_BIT = 0;
  localparam int SLP_SEL_LO  = 1;

  // System control register fields
  localparam int SC_JTAG_OFF  = 7;
  localparam int SC_BOD_OFF   = 6;
  localparam int SC_BOD_UNLK  = 5;
  localparam int SC_PULL_OFF  = 4;
  localparam int SC_VEC_SEL   = 1;
  localparam int SC_VEC_UNLK  = 0;
  localparam logic [7:0] SC_MASK = 8'hF3;

  // Gate register fields
  localparam int GT_TIMER_TWO = 6;

  // Timing counts in clock cycles
  localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
  localparam logic [2:0] BOD_DELAY     = 3'h3;
  localparam logic [2:0] STANDBY_WAKE  = 3'h6;

  // Sleep mode encodings
  typedef enum logic [2:0] {
    MODE_IDLE     = 3'h0,
    MODE_NOISE    = 3'h1,
    MODE_PWR_DOWN = 3'h2,
    MODE_PWR_SAVE = 3'h3,
    MODE_RSVD4    = 3'h4,
    MODE_RSVD5    = 3'h5,
    MODE_STANDBY  = 3'h6,
    MODE_EXT_STBY = 3'h7
  } sleep_mode_type;

  // One CPU register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_type;

  // Execution context for interrupt blocking
  typedef struct packed {
    logic in_boot;
    logic app_lock;
    logic boot_lock;
  } exec_ctx_type;

endpackage : pwr_sys_pkg
